/* File: core/ppcsb_map.vh */
`ifndef PPCSB_MAP_VH
`define PPCSB_MAP_VH
// ============================================================
// Address map (byte addresses, one 32-bit word per register)
`define PPCSB_OFS_DATA         4'h0
`define PPCSB_OFS_CFG          4'h4
`define PPCSB_OFS_PIN          4'h8
`define PPCSB_ADDR_ANALOG      8'h50
`define PPCSB_ADDR_STATUS      8'h54
`define PPCSB_NUM_PORTS        3'h5
// ============================================================
// Port indices (address bits 6:4)
`define PPCSB_PORT_LOW_ANALOG  0
`define PPCSB_PORT_HIGH_ANALOG 1
`define PPCSB_PORT_SPECIAL     2
`define PPCSB_PORT_GENERAL     3
`define PPCSB_PORT_WAKEUP      4
// ============================================================
// Special port field positions
`define PPCSB_BIT_HALT         7
`define PPCSB_BIT_IDLE         6
`define PPCSB_BIT_DELAY        7
`define PPCSB_BIT_ALT_PHASE    6
`define PPCSB_BIT_CLKOUT       7
`define PPCSB_BIT_SERIAL_IN    6
`define PPCSB_BIT_SERIAL_CLK   5
`define PPCSB_BIT_SERIAL_OUT   4
`define PPCSB_BIT_T1_IO        3
`define PPCSB_BIT_T1_CAPTURE   2
`define PPCSB_BIT_WATCHDOG     1
`define PPCSB_BIT_EXT_INT      0
// Wake-up port field positions
`define PPCSB_BIT_T2_B         5
`define PPCSB_BIT_T2_A         4
// Status register field positions
`define PPCSB_STAT_HALT        0
`define PPCSB_STAT_IDLE        1
`define PPCSB_STAT_DELAY       2
// ============================================================
// Reset values and write masks
`define PPCSB_RESET_BYTE       8'h00
`define PPCSB_RESET_ANALOG     16'h0000
`define PPCSB_KEEP_FULL        8'hFF
`define PPCSB_KEEP_SPECIAL     8'h3F
`endif

/* File: core/ppcsb_port.v */
`timescale 1ns/10ps
`include "ppcsb_map.vh"
// ============================================================
// One 8-bit port: configuration and data storage, pin sampling
module ppcsb_port
#(
  parameter [7:0] KEEP = `PPCSB_KEEP_FULL
)
(
  // Clock and reset
  input  wire       pclk,
  input  wire       presetn,
  // Register writes
  input  wire       wr_cfg,
  input  wire       wr_data,
  input  wire [7:0] wdata,
  // Register contents
  output reg  [7:0] cfg,
  output reg  [7:0] data,
  // Pins
  input  wire [7:0] pad_in,
  output reg  [7:0] pin_level
);

  reg [7:0] pin_meta;

  // ============================================================
  // Configuration and data bits
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg  <= `PPCSB_RESET_BYTE;
      data <= `PPCSB_RESET_BYTE;
    end
    else
    begin
      if (wr_cfg)
        cfg <= wdata;
      if (wr_data)
        data <= wdata & KEEP;
    end
  end

  // ============================================================
  // Two-stage pin synchroniser
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_meta  <= `PPCSB_RESET_BYTE;
      pin_level <= `PPCSB_RESET_BYTE;
    end
    else
    begin
      pin_meta  <= pad_in;
      pin_level <= pin_meta;
    end
  end

endmodule

/* File: core/ppcsb_top.v */
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/10ps
`include "ppcsb_map.vh"
module ppcsb_top
(
  // APB slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Port pins, 8 bits per port, port 0 in the low byte
  input  wire [39:0] pad_in,
  output reg  [39:0] pad_out,
  output reg  [39:0] pad_oe,
  output reg  [39:0] pad_pullup,
  // Device control
  input  wire        watchdog_select,
  input  wire        watchdog_signal,
  input  wire        rc_clock_config,
  input  wire        wake_event,
  output reg         halt_mode,
  output reg         idle_mode,
  output reg         main_clock_stop,
  output reg         alt_serial_phase,
  output reg         startup_delay_enable,
  // Alternate pin functions
  output reg         serial_data_in,
  output reg         serial_clock_pin,
  output reg         serial_data_out_pin,
  output reg         timer1_io_pin,
  output reg         timer1_capture_pin,
  output reg         external_interrupt_pin,
  output reg         timer2_input_a,
  output reg         timer2_input_b,
  output reg  [7:0]  wakeup_levels,
  output reg  [15:0] analog_channel_enable
);

  localparam NPORT = 5;
  localparam SP    = `PPCSB_PORT_SPECIAL;

  wire [39:0]     cfg_all;
  wire [39:0]     data_all;
  wire [39:0]     pin_all;
  wire [39:0]     analog_mask;
  wire [NPORT-1:0] wr_cfg;
  wire [NPORT-1:0] wr_data;
  wire            bus_write;
  wire            halt_set;
  wire            idle_set;
  reg  [15:0]     analog_sel;
  reg  [31:0]     rd_value;
  reg             rd_hit;
  reg             wake_meta;
  reg             wake_sync;
  reg             next_halt;
  reg             next_idle;

  // ============================================================
  // Address decode helpers
  function port_reg;
    input [7:0]   addr;
    input integer port;
    input [3:0]   ofs;
    begin
      port_reg = (addr[7] == 1'b0) && (addr[6:4] == port[2:0]) && (addr[3:0] == ofs);
    end
  endfunction

  function mapped;
    input [7:0] addr;
    begin
      mapped = ((addr[7] == 1'b0) && (addr[6:4] < `PPCSB_NUM_PORTS) &&
                ((addr[3:0] == `PPCSB_OFS_DATA) || (addr[3:0] == `PPCSB_OFS_CFG) ||
                 (addr[3:0] == `PPCSB_OFS_PIN))) ||
               (addr == `PPCSB_ADDR_ANALOG) || (addr == `PPCSB_ADDR_STATUS);
    end
  endfunction

  assign bus_write = psel & penable & pready & pwrite;

  // ============================================================
  // Port instances
  genvar p;
  generate
    for (p = 0; p < NPORT; p = p + 1)
    begin : g_port
      assign wr_cfg[p]  = bus_write & port_reg(paddr, p, `PPCSB_OFS_CFG);
      assign wr_data[p] = bus_write & port_reg(paddr, p, `PPCSB_OFS_DATA);
      ppcsb_port
      #(
        .KEEP (p == SP ? `PPCSB_KEEP_SPECIAL : `PPCSB_KEEP_FULL)
      )
      u_port
      (
        .pclk      (pclk),
        .presetn   (presetn),
        .wr_cfg    (wr_cfg[p]),
        .wr_data   (wr_data[p]),
        .wdata     (pwdata[7:0]),
        .cfg       (cfg_all[p*8 +: 8]),
        .data      (data_all[p*8 +: 8]),
        .pad_in    (pad_in[p*8 +: 8]),
        .pin_level (pin_all[p*8 +: 8])
      );
    end
  endgenerate

  // ============================================================
  // Register read mux
  assign analog_mask = {24'h000000, analog_sel};

  always @*
  begin
    rd_value = 32'h00000000;
    rd_hit   = mapped(paddr);
    if (paddr == `PPCSB_ADDR_ANALOG)
      rd_value = {16'h0000, analog_sel};
    else if (paddr == `PPCSB_ADDR_STATUS)
    begin
      rd_value[`PPCSB_STAT_HALT]  = halt_mode;
      rd_value[`PPCSB_STAT_IDLE]  = idle_mode;
      rd_value[`PPCSB_STAT_DELAY] = startup_delay_enable;
    end
    else if (rd_hit)
    begin
      case (paddr[3:0])
        `PPCSB_OFS_DATA:
          rd_value[7:0] = data_all[{paddr[6:4], 3'b000} +: 8];
        `PPCSB_OFS_CFG:
          rd_value[7:0] = cfg_all[{paddr[6:4], 3'b000} +: 8];
        `PPCSB_OFS_PIN:
          rd_value[7:0] = pin_all[{paddr[6:4], 3'b000} +: 8] &
                          ~analog_mask[{paddr[6:4], 3'b000} +: 8];
        default:
          rd_value = 32'h00000000;
      endcase
    end
  end

  // ============================================================
  // APB answer: one wait state, then pready for one cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (psel && penable && !pready)
    begin
      pready  <= 1'b1;
      prdata  <= pwrite ? 32'h00000000 : rd_value;
      pslverr <= ~rd_hit;
    end
    else
    begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
  end

  // ============================================================
  // Analog channel selection
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      analog_sel <= `PPCSB_RESET_ANALOG;
    else if (bus_write && paddr == `PPCSB_ADDR_ANALOG)
      analog_sel <= pwdata[15:0];
  end

  // ============================================================
  // Halt and idle requests; a request wins over a wake in the same cycle
  assign halt_set = wr_data[SP] & pwdata[`PPCSB_BIT_HALT];
  assign idle_set = wr_data[SP] & pwdata[`PPCSB_BIT_IDLE];

  always @*
  begin
    next_halt = halt_mode;
    next_idle = idle_mode;
    if (wake_sync)
    begin
      next_halt = 1'b0;
      next_idle = 1'b0;
    end
    if (halt_set)
      next_halt = 1'b1;
    if (idle_set)
      next_idle = 1'b1;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wake_meta <= 1'b0;
      wake_sync <= 1'b0;
    end
    else
    begin
      wake_meta <= wake_event;
      wake_sync <= wake_meta;
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      halt_mode            <= 1'b0;
      idle_mode            <= 1'b0;
      main_clock_stop      <= 1'b0;
      alt_serial_phase     <= 1'b0;
      startup_delay_enable <= 1'b0;
    end
    else
    begin
      halt_mode            <= next_halt;
      idle_mode            <= next_idle;
      main_clock_stop      <= next_halt;
      alt_serial_phase     <= cfg_all[SP*8 + `PPCSB_BIT_ALT_PHASE];
      startup_delay_enable <= cfg_all[SP*8 + `PPCSB_BIT_DELAY] & rc_clock_config;
    end
  end

  // ============================================================
  // Pad drive, one flop set per pin
  genvar i;
  generate
    for (i = 0; i < 8 * NPORT; i = i + 1)
    begin : g_pad
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          pad_oe[i]     <= 1'b0;
          pad_out[i]    <= 1'b0;
          pad_pullup[i] <= 1'b0;
        end
        else if (i == SP * 8 + `PPCSB_BIT_SERIAL_IN)
        begin
          pad_oe[i]     <= 1'b0;
          pad_out[i]    <= 1'b0;
          pad_pullup[i] <= 1'b0;
        end
        else if (i == SP * 8 + `PPCSB_BIT_CLKOUT)
        begin
          pad_oe[i]     <= 1'b1;
          pad_out[i]    <= ~pad_out[i] & ~next_halt;
          pad_pullup[i] <= 1'b0;
        end
        else if (i == SP * 8 + `PPCSB_BIT_WATCHDOG && watchdog_select)
        begin
          pad_oe[i]     <= ~watchdog_signal;
          pad_out[i]    <= 1'b0;
          pad_pullup[i] <= 1'b1;
        end
        else
        begin
          pad_oe[i]     <= cfg_all[i];
          pad_out[i]    <= data_all[i];
          pad_pullup[i] <= ~cfg_all[i] & data_all[i];
        end
      end
    end
  endgenerate

  // ============================================================
  // Alternate functions fed from synchronised pin levels, analog channel enables from analog_sel
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      serial_data_in         <= 1'b0;
      serial_clock_pin       <= 1'b0;
      serial_data_out_pin    <= 1'b0;
      timer1_io_pin          <= 1'b0;
      timer1_capture_pin     <= 1'b0;
      external_interrupt_pin <= 1'b0;
      timer2_input_a         <= 1'b0;
      timer2_input_b         <= 1'b0;
      wakeup_levels          <= `PPCSB_RESET_BYTE;
      analog_channel_enable  <= `PPCSB_RESET_ANALOG;
    end
    else
    begin
      serial_data_in         <= pin_all[SP*8 + `PPCSB_BIT_SERIAL_IN];
      serial_clock_pin       <= pin_all[SP*8 + `PPCSB_BIT_SERIAL_CLK];
      serial_data_out_pin    <= pin_all[SP*8 + `PPCSB_BIT_SERIAL_OUT];
      timer1_io_pin          <= pin_all[SP*8 + `PPCSB_BIT_T1_IO];
      timer1_capture_pin     <= pin_all[SP*8 + `PPCSB_BIT_T1_CAPTURE];
      external_interrupt_pin <= pin_all[SP*8 + `PPCSB_BIT_EXT_INT];
      timer2_input_a         <= pin_all[`PPCSB_PORT_WAKEUP*8 + `PPCSB_BIT_T2_A];
      timer2_input_b         <= pin_all[`PPCSB_PORT_WAKEUP*8 + `PPCSB_BIT_T2_B];
      wakeup_levels          <= pin_all[`PPCSB_PORT_WAKEUP*8 +: 8];
      analog_channel_enable  <= analog_sel;
    end
  end

endmodule

/* File: verif/ppcsb_asserts.sv */
`timescale 1ns/10ps
module ppcsb_asserts
(
  // APB
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // Pads
  input wire [39:0] pad_out,
  input wire [39:0] pad_oe,
  input wire [39:0] pad_pullup,
  // Device control
  input wire        watchdog_select,
  input wire        watchdog_signal,
  input wire        rc_clock_config,
  input wire        halt_mode,
  input wire        idle_mode,
  input wire        main_clock_stop,
  input wire        startup_delay_enable
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // Properties
  sequence s_req;
    psel && !penable ##1 psel && penable && !pready;
  endsequence
  sequence s_sp_wr(b);
    psel && penable && pwrite && pready && paddr == 8'h20 && pwdata[b];
  endsequence
  // Accepted special data writes with the halt or idle bit set
  wire sp_halt_wr = psel && penable && pwrite && pready && paddr == 8'h20 && pwdata[7];
  wire sp_idle_wr = psel && penable && pwrite && pready && paddr == 8'h20 && pwdata[6];
  wire wdog_rel   = watchdog_select && watchdog_signal;
  property p_ready; s_req |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready not in second access cycle");
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("bad error answer");
  property p_upper; pready |-> prdata[31:16] == 16'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_sp67; pready && !pwrite && paddr == 8'h20 |-> prdata[7:6] == 2'b00; endproperty
  a_sp67: assert property (p_sp67) else $error("special data bits 7:6 not zero");
  property p_six; !pad_oe[22] && !pad_pullup[22]; endproperty
  a_six: assert property (p_six) else $error("special bit six driven");
  property p_clk; pad_oe[23] && !halt_mode |=> halt_mode || pad_out[23] != $past(pad_out[23]); endproperty
  a_clk: assert property (p_clk) else $error("clock output stuck");
  property p_halt; halt_mode && $past(halt_mode) |-> !pad_out[23] && main_clock_stop; endproperty
  a_halt: assert property (p_halt) else $error("clock runs in halt");
  property p_halt_set; $rose(halt_mode) |-> $past(sp_halt_wr); endproperty
  a_halt_set: assert property (p_halt_set) else $error("halt without write");
  property p_idle_set; $rose(idle_mode) |-> $past(sp_idle_wr); endproperty
  a_idle_set: assert property (p_idle_set) else $error("idle without write");
  property p_halt_req; s_sp_wr(7) |=> halt_mode; endproperty
  a_halt_req: assert property (p_halt_req) else $error("halt write ignored");
  property p_idle_req; s_sp_wr(6) |=> idle_mode; endproperty
  a_idle_req: assert property (p_idle_req) else $error("idle write ignored");
  property p_delay; startup_delay_enable |-> $past(rc_clock_config); endproperty
  a_delay: assert property (p_delay) else $error("delay without RC clock");
  property p_pull; (pad_pullup & pad_oe & 40'hFF_FFFD_FFFF) == 40'h0; endproperty
  a_pull: assert property (p_pull) else $error("pull-up on driven pin");
  property p_wdog; $past(presetn) && $past(wdog_rel) |-> !pad_oe[17] && pad_pullup[17];
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog pin not released");
endmodule
bind ppcsb_top ppcsb_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .pad_out, .pad_oe, .pad_pullup, .watchdog_select, .watchdog_signal, .rc_clock_config, .halt_mode,
  .idle_mode, .main_clock_stop, .startup_delay_enable);

/* File: verif/ppcsb_board.sv */
`timescale 1ns/10ps
module ppcsb_board
(
  // Clock
  input  wire        pclk,
  // Block pad controls
  input  wire [39:0] pad_out,
  input  wire [39:0] pad_oe,
  input  wire [39:0] pad_pullup,
  // Board drivers
  input  wire [39:0] ext_en,
  input  wire [39:0] ext_val,
  // Pin levels
  output wire [39:0] pad_in
);
  reg [39:0] float_pat = 40'h00_0000_0000;
  // Undriven pins wander so a stale level never reads back
  always @(posedge pclk)
    float_pat <= ~float_pat;
  // Block drive, then board drive, then pull-up, else floating
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
                | (~pad_oe & ~ext_en & (pad_pullup | float_pat));
endmodule

/* File: verif/ppcsb_top_bench.sv */
`timescale 1ns/10ps
module ppcsb_top_bench;
  reg         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  reg  [7:0]  paddr = 8'h00;
  reg  [31:0] pwdata = 32'h0, rdat;
  reg         watchdog_select = 0, watchdog_signal = 0, rc_clock_config = 1, wake_event = 0, rerr;
  reg  [39:0] ext_en = 40'h0, ext_val = 40'h0;
  wire [31:0] prdata;
  wire        pready, pslverr, halt_mode, idle_mode, main_clock_stop, alt_serial_phase, startup_delay_enable;
  wire        serial_data_in, serial_clock_pin, serial_data_out_pin, timer1_io_pin, timer1_capture_pin;
  wire        external_interrupt_pin, timer2_input_a, timer2_input_b;
  wire [7:0]  wakeup_levels;
  wire [15:0] analog_channel_enable;
  wire [39:0] pad_in, pad_out, pad_oe, pad_pullup;
  integer     n_fail = 0, cmp_count = 0;
  always #20 pclk = ~pclk;
  ppcsb_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pad_in,
    .pad_out, .pad_oe, .pad_pullup, .watchdog_select, .watchdog_signal, .rc_clock_config, .wake_event, .halt_mode,
    .idle_mode, .main_clock_stop, .alt_serial_phase, .startup_delay_enable, .serial_data_in, .serial_clock_pin,
    .serial_data_out_pin, .timer1_io_pin, .timer1_capture_pin, .external_interrupt_pin, .timer2_input_a,
    .timer2_input_b, .wakeup_levels, .analog_channel_enable);
  ppcsb_board board (.pclk, .pad_out, .pad_oe, .pad_pullup, .ext_en, .ext_val, .pad_in);
  // ==========================================================
  // Shared tasks
  task chk(input [39:0] exp, input [39:0] got);
    cmp_count = cmp_count + 1;
    if (got !== exp)
    begin
      n_fail = n_fail + 1;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    integer n;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge pclk);
    chk(1, pready);
    rdat = prdata;
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task rd(input [7:0] a, input [39:0] exp);
    apb(0, a, 32'h0);
    chk(exp, rdat);
  endtask
  task settle;
    repeat (5) @(posedge pclk);
  endtask
  // ==========================================================
  // Scenarios
  task t_reset;
    reg [7:0] a;
    for (a = 8'h00; a < 8'h50; a = a + 8'h10)
    begin
      rd(a, 0);
      rd(a + 8'h04, 0);
    end
    chk(0, pad_oe & 40'hFF_FF7F_FFFF);
    chk(0, pad_pullup);
  endtask
  task t_port;
    ext_en[31:24] <= 8'h03;
    ext_val[31:24] <= 8'h02;
    apb(1, 8'h34, 32'hF0);
    apb(1, 8'h30, 32'hCC);
    rd(8'h34, 32'hF0);
    rd(8'h30, 32'hCC);
    settle;
    chk({8'hF0, 8'hC0, 8'h0C}, {pad_oe[31:24], pad_out[31:28], 4'h0, pad_pullup[31:24]});
    rd(8'h38, 32'hCE);
  endtask
  task t_special;
    apb(1, 8'h20, 32'hFF);
    rd(8'h20, 32'h3F);
    rd(8'h54, 32'h03);
    chk(2'b10, {main_clock_stop, pad_out[23]});
    wake_event <= 1;
    repeat (3) @(posedge pclk);
    wake_event <= 0;
    settle;
    apb(1, 8'h20, 32'h40);
    rd(8'h54, 32'h02);
    wake_event <= 1;
    repeat (3) @(posedge pclk);
    wake_event <= 0;
    apb(1, 8'h24, 32'hC0);
    settle;
    rd(8'h24, 32'hC0);
    chk(6'b110000, {alt_serial_phase, startup_delay_enable, halt_mode, idle_mode, pad_oe[22], pad_pullup[22]});
    rc_clock_config <= 0;
    settle;
    chk(0, startup_delay_enable);
    apb(1, 8'h24, 32'h0);
    apb(1, 8'h20, 32'h0);
  endtask
  task t_analog;
    ext_en[15:0] <= 16'hFFFF;
    ext_val[15:0] <= 16'hFFFF;
    apb(1, 8'h50, 32'h8001);
    settle;
    chk(16'h8001, analog_channel_enable);
    rd(8'h08, 32'hFE);
    rd(8'h18, 32'h7F);
    apb(1, 8'h50, 32'h0);
  endtask
  task t_alt;
    ext_en[39:16] <= 24'hFF_FFFF;
    ext_val[39:16] <= 24'hA5_0059;
    settle;
    chk(6'b101101, {serial_data_in, serial_clock_pin, serial_data_out_pin, timer1_io_pin, timer1_capture_pin,
      external_interrupt_pin});
    chk({8'hA5, 2'b10}, {wakeup_levels, timer2_input_b, timer2_input_a});
  endtask
  task t_wdog;
    apb(1, 8'h24, 32'h02);
    settle;
    chk(2'b10, {pad_oe[17], pad_out[17]});
    watchdog_select <= 1;
    watchdog_signal <= 1;
    settle;
    chk(2'b01, {pad_oe[17], pad_pullup[17]});
    watchdog_signal <= 0;
    settle;
    chk(3'b101, {pad_oe[17], pad_out[17], pad_pullup[17]});
  endtask
  task t_unmapped;
    apb(1, 8'h60, 32'hFF);
    chk(1, rerr);
    rd(8'h60, 0);
    chk(1, rerr);
    apb(1, 8'h38, 32'h0);
    chk(0, rerr);
  endtask
  // ==========================================================
  // Run control
  task print_verdict;
    $display("compares=%0d mismatches=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    #100000;
    n_fail = n_fail + 1;
    print_verdict;
  end
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_reset;
    t_port;
    t_special;
    t_analog;
    t_alt;
    t_wdog;
    t_unmapped;
    print_verdict;
  end
endmodule
